// ---- spc_pkg.sv ----
// shared constants, field layouts and message types for the promotion packet framer
package spc_pkg;
    localparam logic [3:0]  SPC_CTYPE_PROMOTE  = 4'h3;
    localparam logic [7:0]  SPC_NSID_NONE      = 8'hFF;
    localparam int          SPC_SHORT_BITS     = 16;
    localparam int          SPC_LONG_BITS      = 88;
    localparam logic [6:0]  SPC_SHORT_LEN      = 7'h10;
    localparam logic [6:0]  SPC_LONG_LEN       = 7'h58;
    localparam int          SPC_POS_NEG        = 15;
    localparam int          SPC_POS_RES        = 14;
    localparam int          SPC_POS_RQ_HI      = 13;
    localparam int          SPC_POS_RQ_LO      = 11;
    localparam int          SPC_POS_TIME_HI    = 10;
    localparam int          SPC_POS_TIME_LO    = 8;
    localparam int          SPC_POS_NSID_HI    = 7;
    localparam int          SPC_POS_NSID_LO    = 0;
    localparam int          SPC_FIFO_DEPTH     = 8;

    typedef enum logic [2:0]
    {
        SPC_MSG_NONE        = 3'b000,
        SPC_MSG_SVC_REQ     = 3'b001,
        SPC_MSG_BASE_PROMO  = 3'b010,
        SPC_MSG_ACK         = 3'b011,
        SPC_MSG_BASE_REJ    = 3'b100,
        SPC_MSG_SVC_DEMOTE  = 3'b101,
        SPC_MSG_BASE_DEMOTE = 3'b110
    } spc_msg_t;

    typedef struct packed
    {
        logic        negativeFlag;
        logic [2:0]  requesterRxQuality;
        logic [2:0]  keepaliveTimeCode;
        logic [7:0]  newSwitchIdent;
        logic [47:0] needRequesterAddress;
        logic [7:0]  uplinkPathCost;
        logic [7:0]  downlinkPathCost;
        logic        directSwitchCapable;
        logic        multicastCapable;
        logic        robustnessMgmtCapable;
        logic        retxBufferingCapable;
    } spc_fields_t;

    typedef struct packed
    {
        logic        headerDownlinkBit;
        logic        longForm;
        spc_fields_t fields;
    } spc_frame_t;
endpackage : spc_pkg

// ---- spc_fifo.sv ----
// parameterised valid/ready fifo used on the transmit path
`timescale 1ns/1ps
module spc_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
)(
    // clock and reset
    input  wire logic             mclk,
    input  wire logic             rstn,
    // fill side
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    // drain side
    output logic                  outValid,
    input  wire logic             outReady,
    output logic [WIDTH-1:0]      outData
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wrPtr_reg;
    logic [AW-1:0]    rdPtr_reg;
    logic [AW:0]      count_reg;
    wire              doWrite = inValid && inReady;
    wire              doRead  = outValid && outReady;

    logic [AW:0]      countNext;
    logic             inReady_reg;

    // ready comes from a flop so the framer's ready pin is registered too
    assign countNext = count_reg + (AW+1)'(doWrite) - (AW+1)'(doRead);
    assign inReady  = inReady_reg;
    assign outValid = count_reg != '0;
    assign outData  = mem[rdPtr_reg];

    always_ff @(posedge mclk)
    begin
        if (doWrite)
            mem[wrPtr_reg] <= inData;
    end

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            wrPtr_reg <= '0;
            rdPtr_reg <= '0;
            count_reg <= '0;
            inReady_reg <= 1'b1;
        end
        else
        begin
            if (doWrite)
                wrPtr_reg <= (wrPtr_reg == AW'(DEPTH-1)) ? '0 : wrPtr_reg + 1'b1;
            if (doRead)
                rdPtr_reg <= (rdPtr_reg == AW'(DEPTH-1)) ? '0 : rdPtr_reg + 1'b1;
            count_reg   <= countNext;
            inReady_reg <= countNext != (AW+1)'(DEPTH);
        end
    end
endmodule : spc_fifo

// ---- spc_promo_framer.sv ----
// promotion control packet framer: serialises and parses short and long forms
// Operation
// - packet kind is control type three
// - meaning set by direction and type fields
// - first bit is the negative flag
// - reserved bit after flag sent zero
// - three-bit requester receive quality field
// - three-bit keep-alive time code field
// - base promotion restarts the keep-alive timer
// - eight-bit new switch identifier field
// - 48-bit requester address only in request
// - uplink cost only in service request
// - downlink cost only in service request
// - four reserved bits before capabilities, zero
// - direct switch capability flag
// - multicast capability flag
// - robustness management capability flag
// - retransmission buffering capability flag
// - all other messages use short form
// - decode service request and acknowledge
// - decode base promotion message
// - decode base rejection
// - decode service demotion
// - decode base demotion
`timescale 1ns/1ps
module spc_promo_framer
    import spc_pkg::*;
#(
    parameter int FIFO_DEPTH = spc_pkg::SPC_FIFO_DEPTH
)(
    // clock and reset
    input  wire logic                mclk,
    input  wire logic                rstn,
    // transmit request from the mac
    input  wire logic                txValid,
    output logic                     txReady,
    input  wire spc_pkg::spc_frame_t txFrame,
    input  wire logic [3:0]          txControlType,
    // serial transmit stream
    output logic                     txBit,
    output logic                     txBitValid,
    output logic                     txLast,
    input  wire logic                txBitReady,
    // serial receive stream
    input  wire logic                rxBit,
    input  wire logic                rxBitValid,
    input  wire logic                rxLast,
    input  wire logic                rxHeaderDownlinkBit,
    input  wire logic [3:0]          rxControlType,
    // parsed message
    output logic                     rxMsgValid,
    output spc_pkg::spc_msg_t        rxMsgType,
    output spc_pkg::spc_fields_t     rxFields,
    output logic                     rxDropped,
    output logic                     keepaliveRestart
);
    import spc_pkg::*;

    localparam int FW = SPC_LONG_BITS + 2;

    // ---------------- transmit path ----------------
    typedef enum logic [1:0]
    {
        TX_IDLE  = 2'b00,
        TX_SHIFT = 2'b01
    } spc_txst_t;

    spc_txst_t                txState_reg;
    logic [SPC_LONG_BITS-1:0] txShift_reg;
    logic [6:0]               txLeft_reg;
    logic                     txBit_reg;
    logic                     txBitValid_reg;
    logic                     txLast_reg;

    // request words must carry the type; others are accepted but never written into the fifo
    wire txTypeOk = (txControlType == SPC_CTYPE_PROMOTE);

    // long form only for uplink request with no switch id
    wire txIsLong = !txFrame.headerDownlinkBit && !txFrame.fields.negativeFlag
                    && (txFrame.fields.newSwitchIdent == SPC_NSID_NONE);

    wire [SPC_LONG_BITS-1:0] txPacked = txIsLong
        ? {txFrame.fields.negativeFlag, 1'b0,
           txFrame.fields.requesterRxQuality,
           txFrame.fields.keepaliveTimeCode,
           txFrame.fields.newSwitchIdent,
           txFrame.fields.needRequesterAddress,
           txFrame.fields.uplinkPathCost,
           txFrame.fields.downlinkPathCost,
           4'h0,
           txFrame.fields.directSwitchCapable,
           txFrame.fields.multicastCapable,
           txFrame.fields.robustnessMgmtCapable,
           txFrame.fields.retxBufferingCapable}
        : {txFrame.fields.negativeFlag, 1'b0,
           txFrame.fields.requesterRxQuality,
           txFrame.fields.keepaliveTimeCode,
           txFrame.fields.newSwitchIdent, 72'h0};

    wire [FW-1:0] fifoIn = {txIsLong, 1'b1, txPacked};
    wire [FW-1:0] fifoOut;
    wire          fifoOutValid;
    wire          fifoInReady;
    wire          fifoPop = fifoOutValid && (txState_reg == TX_IDLE);

    // a frame of the wrong control type is consumed but never queued
    assign txReady = fifoInReady;

    spc_fifo #(
        .WIDTH (FW),
        .DEPTH (FIFO_DEPTH)
    ) u_txFifo (
        .mclk     (mclk),
        .rstn     (rstn),
        .inValid  (txValid && txTypeOk),
        .inReady  (fifoInReady),
        .inData   (fifoIn),
        .outValid (fifoOutValid),
        .outReady (fifoPop),
        .outData  (fifoOut)
    );

    wire txAdvance = (txState_reg == TX_SHIFT) && (!txBitValid_reg || txBitReady);

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            txState_reg    <= TX_IDLE;
            txShift_reg    <= '0;
            txLeft_reg     <= '0;
            txBit_reg      <= 1'b0;
            txBitValid_reg <= 1'b0;
            txLast_reg     <= 1'b0;
        end
        else if (fifoPop)
        begin
            txShift_reg <= fifoOut[SPC_LONG_BITS-1:0];
            txLeft_reg  <= fifoOut[FW-1] ? SPC_LONG_LEN : SPC_SHORT_LEN;
            txState_reg <= TX_SHIFT;
            // the previous frame's last bit may be taken on this very edge
            if (txBitReady)
            begin
                txBitValid_reg <= 1'b0;
                txLast_reg     <= 1'b0;
            end
        end
        else if (txAdvance)
        begin
            // msb first, one bit per accepted beat
            txBit_reg      <= txShift_reg[SPC_LONG_BITS-1];
            txShift_reg    <= {txShift_reg[SPC_LONG_BITS-2:0], 1'b0};
            txBitValid_reg <= 1'b1;
            txLast_reg     <= (txLeft_reg == 7'h01);
            txLeft_reg     <= txLeft_reg - 7'h01;
            if (txLeft_reg == 7'h01)
                txState_reg <= TX_IDLE;
        end
        else if (txBitReady)
        begin
            txBitValid_reg <= 1'b0;
            txLast_reg     <= 1'b0;
        end
    end

    assign txBit      = txBit_reg;
    assign txBitValid = txBitValid_reg;
    assign txLast     = txLast_reg;

    // ---------------- receive path ----------------
    logic [SPC_LONG_BITS-1:0] rxShift_reg;
    logic [6:0]               rxCount_reg;
    logic                     rxMsgValid_reg;
    spc_msg_t                 rxMsgType_reg;
    spc_fields_t              rxFields_reg;
    logic                     rxDropped_reg;
    logic                     keepalive_reg;

    wire [SPC_LONG_BITS-1:0] rxNext = {rxShift_reg[SPC_LONG_BITS-2:0], rxBit};
    wire [6:0]  rxLen   = rxCount_reg + 7'h01;
    wire        rxEnd   = rxBitValid && rxLast;
    wire        rxShort = (rxLen == SPC_SHORT_LEN);
    wire        rxLong  = (rxLen == SPC_LONG_LEN);
    wire [15:0] rxHead  = rxLong ? rxNext[SPC_LONG_BITS-1:SPC_LONG_BITS-16] : rxNext[15:0];
    wire        rNeg    = rxHead[SPC_POS_NEG];
    wire [7:0]  rNsid   = rxHead[SPC_POS_NSID_HI:SPC_POS_NSID_LO];
    wire        rNone   = (rNsid == SPC_NSID_NONE);
    wire        rDo     = rxHeaderDownlinkBit;

    // type decode from direction, negative flag and switch id
    wire isSvcReq  = !rDo && !rNeg && rNone;
    wire isAck     = !rDo && !rNeg && !rNone;
    wire isBasePro = rDo && !rNeg && !rNone;
    wire isBaseRej = rDo && rNeg && rNone;
    wire isSvcDem  = !rDo && rNeg && !rNone;
    wire isBaseDem = rDo && rNeg && !rNone;

    wire rxTypeOk  = (rxControlType == SPC_CTYPE_PROMOTE);
    // request must be long; every other message short
    wire rxLenOk   = isSvcReq ? rxLong : rxShort;
    wire rxDefined = isSvcReq | isAck | isBasePro | isBaseRej | isSvcDem | isBaseDem;
    wire rxAccept  = rxEnd && rxTypeOk && rxLenOk && rxDefined;

    wire spc_msg_t rxKind = isSvcReq  ? SPC_MSG_SVC_REQ :
                            isAck     ? SPC_MSG_ACK :
                            isBasePro ? SPC_MSG_BASE_PROMO :
                            isBaseRej ? SPC_MSG_BASE_REJ :
                            isSvcDem  ? SPC_MSG_SVC_DEMOTE :
                            isBaseDem ? SPC_MSG_BASE_DEMOTE : SPC_MSG_NONE;

    // optional fields read as zero when absent
    wire spc_fields_t rxParsed = '{
        negativeFlag:          rNeg,
        requesterRxQuality:    rxHead[SPC_POS_RQ_HI:SPC_POS_RQ_LO],
        keepaliveTimeCode:     rxHead[SPC_POS_TIME_HI:SPC_POS_TIME_LO],
        newSwitchIdent:        rNsid,
        needRequesterAddress:  rxLong ? rxNext[71:24] : 48'h0000_0000_0000,
        uplinkPathCost:        rxLong ? rxNext[23:16] : 8'h00,
        downlinkPathCost:      rxLong ? rxNext[15:8]  : 8'h00,
        directSwitchCapable:   rxLong & rxNext[3],
        multicastCapable:      rxLong & rxNext[2],
        robustnessMgmtCapable: rxLong & rxNext[1],
        retxBufferingCapable:  rxLong & rxNext[0]
    };

    always_ff @(posedge mclk or negedge rstn)
    begin
        if (!rstn)
        begin
            rxShift_reg    <= '0;
            rxCount_reg    <= '0;
            rxMsgValid_reg <= 1'b0;
            rxMsgType_reg  <= SPC_MSG_NONE;
            rxFields_reg   <= '0;
            rxDropped_reg  <= 1'b0;
            keepalive_reg  <= 1'b0;
        end
        else
        begin
            rxMsgValid_reg <= rxAccept;
            rxDropped_reg  <= rxEnd && !rxAccept;
            // base promotion restarts keep-alive like a base keep-alive
            keepalive_reg  <= rxAccept && isBasePro;
            if (rxBitValid)
            begin
                rxShift_reg <= rxNext;
                // saturate so an overlong stream still counts as bad length
                rxCount_reg <= rxEnd ? 7'h00 : ((rxCount_reg == 7'h7F) ? rxCount_reg : rxLen);
            end
            if (rxAccept)
            begin
                rxMsgType_reg <= rxKind;
                rxFields_reg  <= rxParsed;
            end
        end
    end

    assign rxMsgValid       = rxMsgValid_reg;
    assign rxMsgType        = rxMsgType_reg;
    assign rxFields         = rxFields_reg;
    assign rxDropped        = rxDropped_reg;
    assign keepaliveRestart = keepalive_reg;

    // ---------------- assertions ----------------
    sequence s_txLastBeat;
        txBitValid && txLast && txBitReady;
    endsequence

    property p_txLastOnce;
        @(posedge mclk) disable iff (!rstn)
        s_txLastBeat |=> !txLast;
    endproperty
    a_txLastOnce: assert property (p_txLastOnce) else $error("last bit offered twice");

    property p_txHold;
        @(posedge mclk) disable iff (!rstn)
        (txBitValid && !txBitReady) |=> txBitValid && $stable(txBit) && $stable(txLast);
    endproperty
    a_txHold: assert property (p_txHold) else $error("tx bit changed before it was taken");

    property p_txResZero;
        @(posedge mclk) disable iff (!rstn)
        fifoPop |=> txShift_reg[SPC_LONG_BITS-2] == 1'b0;
    endproperty
    a_txResZero: assert property (p_txResZero) else $error("reserved bit after flag not zero");

    property p_txCapResZero;
        @(posedge mclk) disable iff (!rstn)
        (fifoPop && fifoOut[FW-1]) |=> txShift_reg[7:4] == 4'h0;
    endproperty
    a_txCapResZero: assert property (p_txCapResZero) else $error("capability reserved bits not zero");

    property p_txLongOnlyReq;
        @(posedge mclk) disable iff (!rstn)
        (fifoPop && fifoOut[FW-1]) |=> !txShift_reg[SPC_LONG_BITS-1]
            && txShift_reg[SPC_LONG_BITS-9:SPC_LONG_BITS-16] == SPC_NSID_NONE;
    endproperty
    a_txLongOnlyReq: assert property (p_txLongOnlyReq) else $error("long form used for a non-request");

    property p_keepalive;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && isBasePro) |=> keepaliveRestart && rxMsgType == SPC_MSG_BASE_PROMO;
    endproperty
    a_keepalive: assert property (p_keepalive) else $error("keep-alive restart missing");

    property p_keepOnlyPromo;
        @(posedge mclk) disable iff (!rstn)
        keepaliveRestart |-> rxMsgValid && rxMsgType == SPC_MSG_BASE_PROMO;
    endproperty
    a_keepOnlyPromo: assert property (p_keepOnlyPromo) else $error("spurious keep-alive restart");

    property p_svcReqLong;
        @(posedge mclk) disable iff (!rstn)
        (rxEnd && rxTypeOk && isSvcReq && !rxLong) |=> rxDropped && !rxMsgValid;
    endproperty
    a_svcReqLong: assert property (p_svcReqLong) else $error("short request not dropped");

    property p_badType;
        @(posedge mclk) disable iff (!rstn)
        (rxEnd && !rxTypeOk) |=> rxDropped;
    endproperty
    a_badType: assert property (p_badType) else $error("wrong control type accepted");

    property p_rejDecode;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && rDo && rNeg && rNone) |=> rxMsgType == SPC_MSG_BASE_REJ;
    endproperty
    a_rejDecode: assert property (p_rejDecode) else $error("reject misdecoded");

    property p_ackDecode;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && !rDo && !rNeg && !rNone) |=> rxMsgType == SPC_MSG_ACK && rxFields.newSwitchIdent != SPC_NSID_NONE;
    endproperty
    a_ackDecode: assert property (p_ackDecode) else $error("acknowledge misdecoded");

    property p_demDecode;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && rNeg && !rNone) |=> rxMsgType == (rDo ? SPC_MSG_BASE_DEMOTE : SPC_MSG_SVC_DEMOTE);
    endproperty
    a_demDecode: assert property (p_demDecode) else $error("demotion misdecoded");

    property p_shortNoAddr;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && rxShort) |=> rxFields.needRequesterAddress == 48'h0000_0000_0000 && !rxFields.multicastCapable;
    endproperty
    a_shortNoAddr: assert property (p_shortNoAddr) else $error("short form carries long fields");

    property p_svcReqDecode;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && isSvcReq) |=> rxMsgType == SPC_MSG_SVC_REQ && rxFields.newSwitchIdent == SPC_NSID_NONE;
    endproperty
    a_svcReqDecode: assert property (p_svcReqDecode) else $error("service request misdecoded");

    property p_baseProDecode;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && rDo && !rNeg && !rNone) |=> rxMsgType == SPC_MSG_BASE_PROMO;
    endproperty
    a_baseProDecode: assert property (p_baseProDecode) else $error("base promotion misdecoded");

    property p_undefDrop;
        @(posedge mclk) disable iff (!rstn)
        (rxEnd && rDo && !rNeg && rNone) |=> rxDropped && !rxMsgValid;
    endproperty
    a_undefDrop: assert property (p_undefDrop) else $error("undefined combination accepted");

    property p_costs;
        @(posedge mclk) disable iff (!rstn)
        (rxAccept && rxLong) |=> rxFields.uplinkPathCost == $past(rxNext[23:16])
            && rxFields.downlinkPathCost == $past(rxNext[15:8]);
    endproperty
    a_costs: assert property (p_costs) else $error("path costs misparsed");

    property p_rxPulse;
        @(posedge mclk) disable iff (!rstn)
        rxMsgValid |=> !rxMsgValid;
    endproperty
    a_rxPulse: assert property (p_rxPulse) else $error("message valid longer than one cycle");
endmodule : spc_promo_framer

// ---- spc_peer_sink.sv ----
// serial sink standing in for the peer mac on the transmit stream
`timescale 1ns/1ps
module spc_peer_sink (
    // clock and reset
    input  wire logic mclk,
    input  wire logic rstn,
    // stream from the framer
    input  wire logic txBit,
    input  wire logic txBitValid,
    input  wire logic txLast,
    output logic      txBitReady,
    // pacing set by the bench
    input  wire logic slow,
    input  wire logic stall
);
    logic [87:0] shiftReg;
    int          cnt;
    logic [87:0] got[$];
    int          gotLen[$];

    initial txBitReady = 1'b0;

    // ready moves off the sampling edge; random gaps prove the framer holds each bit
    always @(negedge mclk)
        txBitReady <= !stall && (!slow || $urandom_range(1));

    always @(posedge mclk or negedge rstn)
        if (!rstn)
        begin
            shiftReg = '0;
            cnt = 0;
        end
        else if (txBitValid && txBitReady)
        begin
            shiftReg = {shiftReg[86:0], txBit};
            cnt++;
            if (txLast)
            begin
                got.push_back(shiftReg);
                gotLen.push_back(cnt);
                cnt = 0;
                shiftReg = '0;
            end
        end
endmodule : spc_peer_sink

// ---- test_switch_promotion_ctrl_packet.sv ----
// self-checking bench for the promotion packet framer
`timescale 1ns/1ps
module test_switch_promotion_ctrl_packet;
    import spc_pkg::*;

    logic        mclk = 0, rstn = 0, slow = 1, stall = 0;
    logic        txValid = 0, txBit, txBitValid, txLast, txBitReady, txReady;
    spc_frame_t  txFrame = '0;
    logic [3:0]  txControlType = '0, rxControlType = '0;
    logic        rxBit = 0, rxBitValid = 0, rxLast = 0, rxHeaderDownlinkBit = 0;
    logic        rxMsgValid, rxDropped, keepaliveRestart;
    spc_msg_t    rxMsgType;
    spc_fields_t rxFields;
    int          fail_count = 0, compares = 0, cyc = 0;
    logic [87:0] expQ[$];
    int          expL[$];

    spc_promo_framer #(.FIFO_DEPTH(SPC_FIFO_DEPTH)) i_dut (.mclk, .rstn, .txValid, .txReady, .txFrame,
        .txControlType, .txBit, .txBitValid, .txLast, .txBitReady, .rxBit, .rxBitValid, .rxLast,
        .rxHeaderDownlinkBit, .rxControlType, .rxMsgValid, .rxMsgType, .rxFields, .rxDropped, .keepaliveRestart);
    spc_peer_sink i_peer (.mclk, .rstn, .txBit, .txBitValid, .txLast, .txBitReady, .slow, .stall);

    always #2.5 mclk = ~mclk;

    task automatic final_report();
        if (fail_count == 0 && compares > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : final_report

    // a hung handshake ends here rather than running forever
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 40000)
        begin
            fail_count++;
            $display("[ERR] %0t run did not finish", $time);
            final_report();
        end
    end

    task automatic chk(logic [127:0] seen, logic [127:0] exp, string what);
        compares++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("[ERR] %0t %s seen %0h expected %0h", $time, what, seen, exp);
        end
    endtask : chk

    function automatic logic [87:0] ser(spc_fields_t f, logic lf, logic r1, logic [3:0] r4);
        if (lf)
            return {f.negativeFlag, r1, f.requesterRxQuality, f.keepaliveTimeCode, f.newSwitchIdent,
                    f.needRequesterAddress, f.uplinkPathCost, f.downlinkPathCost, r4,
                    f.directSwitchCapable, f.multicastCapable, f.robustnessMgmtCapable, f.retxBufferingCapable};
        return {72'h0, f.negativeFlag, r1, f.requesterRxQuality, f.keepaliveTimeCode, f.newSwitchIdent};
    endfunction : ser

    // identifier below FF leans on FE, the boundary
    function automatic spc_fields_t rndFields(logic neg, logic ff);
        logic [95:0] r;
        spc_fields_t f;
        r = {$urandom, $urandom, $urandom};
        f = r[82:0];
        f.negativeFlag = neg;
        f.newSwitchIdent = ff ? SPC_NSID_NONE : (r[90] ? 8'hFE : {1'b0, r[89:83]});
        return f;
    endfunction : rndFields

    function automatic spc_msg_t expType(logic dl, logic neg, logic ff, logic lf, logic [3:0] ct);
        spc_msg_t t;
        case ({dl, neg, ff})
            3'b001: t = SPC_MSG_SVC_REQ;
            3'b000: t = SPC_MSG_ACK;
            3'b100: t = SPC_MSG_BASE_PROMO;
            3'b111: t = SPC_MSG_BASE_REJ;
            3'b010: t = SPC_MSG_SVC_DEMOTE;
            3'b110: t = SPC_MSG_BASE_DEMOTE;
            default: t = SPC_MSG_NONE;
        endcase
        if (ct != SPC_CTYPE_PROMOTE || lf != (t == SPC_MSG_SVC_REQ))
            t = SPC_MSG_NONE;
        return t;
    endfunction : expType

    // leaves txValid high so calls run back to back; caller lowers it
    task automatic sendTx(logic dl, spc_fields_t f, logic [3:0] ct);
        logic lf;
        lf = !dl && !f.negativeFlag && f.newSwitchIdent == SPC_NSID_NONE;
        txFrame = {dl, 1'b0, f};
        txControlType = ct;
        txValid = 1'b1;
        while (txReady !== 1'b1)
            @(negedge mclk);
        @(negedge mclk);
        if (ct == SPC_CTYPE_PROMOTE)
        begin
            expQ.push_back(ser(f, lf, 1'b0, 4'h0));
            expL.push_back(lf ? SPC_LONG_BITS : SPC_SHORT_BITS);
        end
    endtask : sendTx

    task automatic sendRx(logic dl, logic [3:0] ct, logic [87:0] bits, int len, spc_msg_t et, spc_fields_t ef);
        for (int i = len - 1; i >= 0; i--)
        begin
            rxBitValid = 1'b1;
            rxBit = bits[i];
            rxLast = (i == 0);
            rxHeaderDownlinkBit = dl;
            rxControlType = ct;
            @(negedge mclk);
        end
        // the answer pulses only in the cycle after the last beat
        chk(rxMsgValid, et != SPC_MSG_NONE, "message valid");
        chk(rxDropped, et == SPC_MSG_NONE, "message dropped");
        chk(keepaliveRestart, et == SPC_MSG_BASE_PROMO, "keepalive restart");
        if (et != SPC_MSG_NONE)
        begin
            chk(rxMsgType, et, "message type");
            chk(rxFields, ef, "parsed fields");
        end
        rxBitValid = 1'b0;
        rxLast = 1'b0;
        rxBit = ~rxBit;
        @(negedge mclk);
    endtask : sendRx

    initial
    begin
        spc_fields_t f;
        logic        lf;
        logic [3:0]  ct;
        int          acc;
        void'($urandom(32'h5935));
        repeat (12) @(negedge mclk);
        rstn = 1'b1;
        // every direction, flag and identifier mix, two foreign control types among them
        for (int i = 0; i < 24; i++)
            sendTx(i[2], rndFields(i[1], i[0]), (i % 11 == 5) ? 4'h5 : SPC_CTYPE_PROMOTE);
        txValid = 1'b0;
        while (i_peer.got.size() < expQ.size())
            @(negedge mclk);
        // sink stalled: queue until refused, then drain with random gaps
        stall = 1'b1;
        acc = 0;
        repeat (4) @(negedge mclk);
        while (txReady === 1'b1 && acc < 12)
        begin
            sendTx(1'b1, rndFields(1'b0, 1'b0), SPC_CTYPE_PROMOTE);
            acc++;
        end
        txValid = 1'b0;
        chk(acc >= SPC_FIFO_DEPTH && acc <= SPC_FIFO_DEPTH + 1, 1'b1, "frames queued before refusal");
        stall = 1'b0;
        while (i_peer.got.size() < expQ.size())
            @(negedge mclk);
        repeat (3) @(negedge mclk);
        chk(txBitValid, 1'b0, "stream idle");
        chk(i_peer.got.size(), expQ.size(), "frame count");
        foreach (expQ[k])
        begin
            chk(i_peer.got[k], expQ[k], "sent bits");
            chk(i_peer.gotLen[k], expL[k], "sent length");
        end
        // receive: all mixes in both lengths, with and without the right control type
        for (int i = 0; i < 32; i++)
        begin
            lf = i[3];
            ct = i[4] ? SPC_CTYPE_PROMOTE : (4'($urandom_range(15)) | 4'h4);
            f = rndFields(i[1], i[0]);
            sendRx(i[2], ct, ser(f, lf, 1'($urandom), 4'($urandom)), lf ? SPC_LONG_BITS : SPC_SHORT_BITS,
                   expType(i[2], i[1], i[0], lf, ct),
                   lf ? f : {f.negativeFlag, f.requesterRxQuality, f.keepaliveTimeCode, f.newSwitchIdent, 68'h0});
        end
        final_report();
    end
endmodule : test_switch_promotion_ctrl_packet
